// file: core/serial_channel_pkg.sv
// Purpose: Constants, register map and types shared by the serial channel core.
// Assumes: Byte-wide register port with a 4-bit register index.
// Notes: Register fields are packed structs so the core can carry them whole.
package serial_channel_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] OFS_FRAME_CONTROL = 4'h0;
    localparam logic [3:0] OFS_CLOCK_SELECT = 4'h1;
    localparam logic [3:0] OFS_BAUD_DIVIDE = 4'h2;
    localparam logic [3:0] OFS_RX_DATA = 4'h3;
    localparam logic [3:0] OFS_TX_DATA = 4'h4;
    localparam logic [3:0] OFS_RX_STATUS = 4'h5;

    // Reset values
    localparam logic [7:0] RST_FRAME_CONTROL = 8'h00;
    localparam logic [3:0] RST_CLOCK_SELECT = 4'h0;
    localparam logic [7:0] RST_BAUD_DIVIDE = 8'hFF;
    localparam logic [7:0] RST_RX_DATA = 8'hFF;
    localparam logic [7:0] RST_RX_SHIFT = 8'hFF;

    // Status register bit positions
    localparam int POS_TX_BUSY = 7;
    localparam int POS_PARITY_ERR = 2;
    localparam int POS_FRAMING_ERR = 1;
    localparam int POS_OVERRUN_ERR = 0;

    // Base clock selection codes
    localparam logic [3:0] CKS_MAX_DIV = 4'hA;
    localparam logic [3:0] CKS_EXTERNAL = 4'hB;
    localparam int PRESCALE_W = 10;

    // Parity select encodings
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    // Frame control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic unit_power_bit;      // Bit 7
        logic tx_enable_bit;       // Bit 6
        logic rx_enable_bit;       // Bit 5
        logic msb_first;           // Bit 4
        logic [1:0] parity_select; // Bits 3:2
        logic char_8bit;           // Bit 1
        logic stop_2bit;           // Bit 0
    } frame_ctrl_s;

    // Receive error flags as one group
    typedef struct packed {
        logic parity_err_flag;
        logic framing_err_flag;
        logic overrun_err_flag;
    } rx_err_s;

endpackage : serial_channel_pkg

// file: core/serial_channel.sv
// Purpose: Asynchronous serial transmit and receive channel with register port.
// Assumes: One clock clk_sys at 50 MHz, synchronous active-low reset_n.
// Notes: Divisor values below 4 and undefined clock codes are not guarded.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module serial_channel
    import serial_channel_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic serial_in_pin,
    input wire logic ext_base_clk,
    output logic serial_out_pin,
    output logic tx_enable_irq,
    output logic rx_done_irq
);

    // Parity bit sent for a data word under a parity mode
    function automatic logic parity_bit(input logic [7:0] data, input logic [1:0] mode);
        logic p;
        p = 1'b0;
        case (mode)
            PAR_EVEN: p = ^data;
            PAR_ODD: p = ~(^data);
            default: p = 1'b0;
        endcase
        return p;
    endfunction : parity_bit

    // Mirror a character so that MSB-first frames shift out LSB first
    function automatic logic [7:0] order_data(input logic [7:0] data, input logic msb,
                                              input logic eight);
        logic [7:0] r;
        r = data;
        if (msb) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = data[7 - i];
            end
            if (!eight) begin
                r = {1'b0, r[7:1]};
            end
        end
        return r;
    endfunction : order_data

    // Base clock tick for a power-of-two divide of the main clock
    function automatic logic div_tick(input logic [PRESCALE_W-1:0] cnt, input logic [3:0] m);
        logic [PRESCALE_W-1:0] mask;
        mask = (PRESCALE_W'(1) << m) - PRESCALE_W'(1);
        return ((cnt & mask) == mask);
    endfunction : div_tick

    // Register storage
    frame_ctrl_s ctrl_q;              // Frame control register
    logic [3:0] clk_sel_q;            // Clock select register
    logic [7:0] baud_div_q;           // Baud divide register
    logic [7:0] rx_data_q;            // Receive data register
    logic [7:0] tx_data_q;            // Transmit data register
    logic tx_pending_q;               // Transmit data register holds a word
    logic rx_unread_q;                // Receive data not yet read
    rx_err_s err_q;                   // Receive error flags
    logic [7:0] rdata_q;              // Read data stage

    // Derived enables
    logic rx_on;
    logic tx_on;
    assign rx_on = ctrl_q.unit_power_bit & ctrl_q.rx_enable_bit;
    assign tx_on = ctrl_q.unit_power_bit & ctrl_q.tx_enable_bit;

    // Pin synchronisers
    logic [1:0] rxd_sync_q;           // Serial input, two stages
    logic [2:0] ext_sync_q;           // External clock, two stages plus edge history

    // Prescaler and base tick
    logic [PRESCALE_W-1:0] pre_cnt_q; // Main clock prescaler
    logic base_tick;                  // One cycle per base clock period

    // Noise filter
    logic filt_a_q;
    logic filt_b_q;
    logic filt_c_q;
    logic rxd_filt_q;                 // Filtered receive level
    logic rxd_prev_q;                 // Filtered level one base tick ago

    // Receive timing and data
    typedef enum logic [5:0] {
        RX_IDLE = 6'h01,
        RX_ARMED = 6'h02,
        RX_START = 6'h04,
        RX_DATA = 6'h08,
        RX_PARITY = 6'h10,
        RX_STOP = 6'h20
    } rx_state_e;
    rx_state_e rx_state_q;
    logic [7:0] rx_div_q;             // Receive divider count
    logic rx_phase_q;                 // Half-bit phase of the receiver
    logic rx_half;                    // Receive half-bit tick
    logic rx_sample;                  // Receive bit-middle strobe
    logic [7:0] rx_shift_q;           // Receive shift register
    logic [3:0] rx_bits_q;            // Data bits received
    logic rx_par_q;                   // Received parity bit
    logic rx_fall;                    // Falling edge on filtered input
    logic rx_rise;                    // Rising edge on filtered input

    // Transmit timing and data
    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_SHIFT = 2'h2
    } tx_state_e;
    tx_state_e tx_state_q;
    logic [7:0] tx_div_q;             // Transmit divider count
    logic tx_phase_q;                 // Half-bit phase of the transmitter
    logic tx_half;                    // Transmit half-bit tick
    logic tx_bit_end;                 // End of a transmitted bit
    logic [11:0] tx_shift_q;          // Transmit shift register
    logic [3:0] tx_left_q;            // Bits left in the frame
    logic tx_load;                    // Transmit data enters the shift register
    logic [11:0] tx_frame;            // Frame built from the data register
    logic [3:0] tx_len;               // Bits in that frame

    // Register port strobes
    logic wr_ctrl;
    logic wr_cks;
    logic wr_div;
    logic wr_tx;
    logic wr_stat;
    logic rd_rx;
    assign wr_ctrl = reg_write && (reg_addr == OFS_FRAME_CONTROL);
    assign wr_cks = reg_write && (reg_addr == OFS_CLOCK_SELECT);
    assign wr_div = reg_write && (reg_addr == OFS_BAUD_DIVIDE);
    assign wr_tx = reg_write && (reg_addr == OFS_TX_DATA);
    assign wr_stat = reg_write && (reg_addr == OFS_RX_STATUS);
    assign rd_rx = reg_read && (reg_addr == OFS_RX_DATA);

    // Control registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_q <= frame_ctrl_s'(RST_FRAME_CONTROL);
            clk_sel_q <= RST_CLOCK_SELECT;
            baud_div_q <= RST_BAUD_DIVIDE;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= frame_ctrl_s'(reg_wdata);
            end
            if (wr_cks) begin
                clk_sel_q <= reg_wdata[3:0];
            end
            if (wr_div) begin
                baud_div_q <= reg_wdata;
            end
        end
    end

    // Read data, valid in the cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                OFS_FRAME_CONTROL: rdata_q <= ctrl_q;
                OFS_CLOCK_SELECT: rdata_q <= {4'h0, clk_sel_q};
                OFS_BAUD_DIVIDE: rdata_q <= baud_div_q;
                OFS_RX_DATA: rdata_q <= rx_data_q;
                OFS_TX_DATA: rdata_q <= tx_data_q;
                OFS_RX_STATUS: begin
                    rdata_q <= 8'h00;
                    rdata_q[POS_TX_BUSY] <= (tx_state_q == TX_SHIFT);
                    rdata_q[POS_PARITY_ERR] <= err_q.parity_err_flag;
                    rdata_q[POS_FRAMING_ERR] <= err_q.framing_err_flag;
                    rdata_q[POS_OVERRUN_ERR] <= err_q.overrun_err_flag;
                end
                default: rdata_q <= 8'h00; // Unmapped reads return zero
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // Pin synchronisers; first stages feed only the second stages
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rxd_sync_q <= 2'h3;
            ext_sync_q <= 3'h0;
        end else begin
            rxd_sync_q <= {rxd_sync_q[0], serial_in_pin};
            ext_sync_q <= {ext_sync_q[1:0], ext_base_clk};
        end
    end

    // Prescaler, held cleared while the unit is off
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !ctrl_q.unit_power_bit) begin
            pre_cnt_q <= '0;
        end else begin
            pre_cnt_q <= pre_cnt_q + PRESCALE_W'(1);
        end
    end

    // Base clock selection and gating
    always_comb begin
        base_tick = 1'b0;
        if (ctrl_q.unit_power_bit) begin
            if (clk_sel_q <= CKS_MAX_DIV) begin
                base_tick = div_tick(pre_cnt_q, clk_sel_q);
            end else if (clk_sel_q == CKS_EXTERNAL) begin
                base_tick = ext_sync_q[1] & ~ext_sync_q[2];
            end
        end
    end

    // Noise filter: three stages on the base clock, two-sample match
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            filt_a_q <= 1'b1;
            filt_b_q <= 1'b1;
            filt_c_q <= 1'b1;
            rxd_filt_q <= 1'b1;
            rxd_prev_q <= 1'b1;
        end else if (base_tick) begin
            filt_a_q <= rxd_sync_q[1];
            filt_b_q <= filt_a_q;
            filt_c_q <= filt_b_q;
            if (filt_b_q == filt_c_q) begin
                rxd_filt_q <= filt_c_q;
            end
            rxd_prev_q <= rxd_filt_q;
        end
    end
    assign rx_rise = base_tick & rxd_filt_q & ~rxd_prev_q;
    assign rx_fall = base_tick & ~rxd_filt_q & rxd_prev_q;

    // Receive divider, restarted at the start edge
    always_ff @(posedge clk_sys) begin
        if (!reset_n || (rx_state_q == RX_ARMED && rx_fall)) begin
            rx_div_q <= 8'h00;
            rx_phase_q <= 1'b1; // First half tick lands mid start bit
        end else if (rx_half) begin
            rx_div_q <= 8'h00;
            rx_phase_q <= ~rx_phase_q;
        end else if (base_tick) begin
            rx_div_q <= rx_div_q + 8'h01;
        end
    end
    assign rx_half = base_tick && (rx_div_q == baud_div_q - 8'h01);
    assign rx_sample = rx_half & rx_phase_q;

    // Receive sequencer
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !rx_on) begin
            rx_state_q <= RX_IDLE;
            rx_bits_q <= 4'h0;
            rx_par_q <= 1'b0;
            rx_shift_q <= RST_RX_SHIFT;
        end else begin
            case (rx_state_q)
                RX_IDLE: begin
                    if (rx_rise) begin
                        rx_state_q <= RX_ARMED;
                    end
                end
                RX_ARMED: begin
                    if (rx_fall) begin
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_sample) begin
                        rx_bits_q <= 4'h0;
                        rx_state_q <= rxd_filt_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_q <= ctrl_q.msb_first ? {rx_shift_q[6:0], rxd_filt_q}
                                                       : {rxd_filt_q, rx_shift_q[7:1]};
                        rx_bits_q <= rx_bits_q + 4'h1;
                        if (rx_bits_q == (ctrl_q.char_8bit ? 4'h7 : 4'h6)) begin
                            rx_state_q <= (ctrl_q.parity_select == PAR_NONE) ? RX_STOP
                                                                             : RX_PARITY;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rx_sample) begin
                        rx_par_q <= rxd_filt_q;
                        rx_state_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // Frame completion: errors, data transfer and interrupt
    logic rx_done;
    logic [7:0] rx_word;
    logic pe_set;
    logic fe_set;
    logic ov_set;
    assign rx_done = rx_on && (rx_state_q == RX_STOP) && rx_sample;
    always_comb begin
        rx_word = rx_shift_q;
        if (!ctrl_q.char_8bit) begin
            rx_word = ctrl_q.msb_first ? {1'b0, rx_shift_q[6:0]} : {1'b0, rx_shift_q[7:1]};
        end
    end
    assign pe_set = rx_done && ctrl_q.parity_select[1] &&
                    ((^rx_word ^ rx_par_q) != (ctrl_q.parity_select == PAR_ODD));
    assign fe_set = rx_done && !rxd_filt_q;
    assign ov_set = rx_done && rx_unread_q;

    // Receive data register and unread tracking
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_data_q <= RST_RX_DATA;
            rx_unread_q <= 1'b0;
        end else begin
            if (rx_done && !rx_unread_q) begin
                rx_data_q <= rx_word;
            end
            if (rx_done) begin
                rx_unread_q <= 1'b1; // New completion wins over a read
            end else if (rd_rx) begin
                rx_unread_q <= 1'b0;
            end
        end
    end

    // Error flags: hardware set wins over a software clear by writing zero
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            err_q <= '0;
        end else begin
            err_q.parity_err_flag <= pe_set | (err_q.parity_err_flag &
                                     ~(wr_stat & ~reg_wdata[POS_PARITY_ERR]));
            err_q.framing_err_flag <= fe_set | (err_q.framing_err_flag &
                                      ~(wr_stat & ~reg_wdata[POS_FRAMING_ERR]));
            err_q.overrun_err_flag <= ov_set | (err_q.overrun_err_flag &
                                      ~(wr_stat & ~reg_wdata[POS_OVERRUN_ERR]));
        end
    end

    // Receive-complete pulse, only while reception is enabled
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_done_irq <= 1'b0;
        end else begin
            rx_done_irq <= rx_done;
        end
    end

    // Transmit frame assembly from the data register
    always_comb begin
        logic [7:0] d;
        logic [3:0] n;
        logic [11:0] f;
        d = order_data(tx_data_q, ctrl_q.msb_first, ctrl_q.char_8bit);
        f = 12'hFFF;
        n = ctrl_q.char_8bit ? 4'h9 : 4'h8; // Start plus character bits
        if (ctrl_q.char_8bit) begin
            f[8:0] = {d, 1'b0};
        end else begin
            f[7:0] = {d[6:0], 1'b0};
        end
        if (ctrl_q.parity_select != PAR_NONE) begin
            f[n] = parity_bit(ctrl_q.char_8bit ? tx_data_q : {1'b0, tx_data_q[6:0]},
                              ctrl_q.parity_select);
            n = n + 4'h1;
        end
        n = n + (ctrl_q.stop_2bit ? 4'h2 : 4'h1);
        tx_frame = f;
        tx_len = n;
    end

    // Transmit divider, restarted with each frame
    always_ff @(posedge clk_sys) begin
        if (!reset_n || tx_load) begin
            tx_div_q <= 8'h00;
            tx_phase_q <= 1'b0;
        end else if (tx_half) begin
            tx_div_q <= 8'h00;
            tx_phase_q <= ~tx_phase_q;
        end else if (base_tick) begin
            tx_div_q <= tx_div_q + 8'h01;
        end
    end
    assign tx_half = base_tick && (tx_div_q == baud_div_q - 8'h01);
    assign tx_bit_end = tx_half & tx_phase_q;
    assign tx_load = tx_on && tx_pending_q &&
                     ((tx_state_q == TX_IDLE) || (tx_bit_end && tx_left_q == 4'h1));

    // Transmit data register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_data_q <= 8'h00;
            tx_pending_q <= 1'b0;
        end else begin
            if (wr_tx) begin
                tx_data_q <= reg_wdata;
            end
            if (wr_tx) begin
                tx_pending_q <= 1'b1;
            end else if (tx_load) begin
                tx_pending_q <= 1'b0;
            end
        end
    end

    // Transmit shifter with back-to-back reload
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !tx_on) begin
            tx_state_q <= TX_IDLE;
            tx_shift_q <= 12'hFFF;
            tx_left_q <= 4'h0;
        end else if (tx_load) begin
            tx_state_q <= TX_SHIFT;
            tx_shift_q <= tx_frame;
            tx_left_q <= tx_len;
        end else if (tx_state_q == TX_SHIFT && tx_bit_end) begin
            tx_shift_q <= {1'b1, tx_shift_q[11:1]};
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) begin
                tx_state_q <= TX_IDLE;
            end
        end
    end

    // Serial output and transmit-enable pulse
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            serial_out_pin <= 1'b1;
            tx_enable_irq <= 1'b0;
        end else begin
            serial_out_pin <= (tx_state_q == TX_SHIFT) ? tx_shift_q[0] : 1'b1;
            tx_enable_irq <= tx_load;
        end
    end

endmodule : serial_channel

`default_nettype wire

// file: tb/serial_channel_sva.sv
// Purpose: Port-level checks for the serial channel core.
// Assumes: One clock, synchronous active-low reset.
// Notes: A bit lasts at least eight clocks, since k is at least 4.
`timescale 1ns/1ps
`default_nettype none
module serial_channel_sva
    import serial_channel_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic serial_in_pin,
    input wire logic ext_base_clk,
    input wire logic serial_out_pin,
    input wire logic tx_enable_irq,
    input wire logic rx_done_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Interrupts are lone pulses
    a_tx_irq_pulse: assert property (tx_enable_irq |=> (!tx_enable_irq) [*8])
        else $error("tx irq repeated");
    a_rx_irq_pulse: assert property (rx_done_irq |=> (!rx_done_irq) [*8])
        else $error("rx irq repeated");
    // Start bit goes out one cycle after the load pulse and lasts a whole bit
    a_start_low: assert property (tx_enable_irq |=> (!serial_out_pin) [*8])
        else $error("start bit missing");
    a_busy_load: assert property (tx_enable_irq ##1 reg_read && reg_addr == OFS_RX_STATUS
        |=> reg_rdata[POS_TX_BUSY]) else $error("busy flag low while shifting");
    // Read data stands only after a read
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (reg_read && reg_addr > OFS_RX_STATUS |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_err_clear: assert property (reg_write && reg_addr == OFS_RX_STATUS && reg_wdata[2:0] == 3'h0
        ##2 reg_read && reg_addr == OFS_RX_STATUS |=> reg_rdata[2:0] == 3'h0)
        else $error("error flags not cleared");
    // Power off drops the line to idle
    a_power_idle: assert property (reg_write && reg_addr == OFS_FRAME_CONTROL && !reg_wdata[7]
        |-> ##[1:3] serial_out_pin) else $error("line not idle after power off");
endmodule : serial_channel_sva
bind serial_channel serial_channel_sva serial_channel_sva_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin), .ext_base_clk(ext_base_clk),
    .serial_out_pin(serial_out_pin), .tx_enable_irq(tx_enable_irq), .rx_done_irq(rx_done_irq));
`default_nettype wire

// file: tb/remote_node.sv
// Purpose: Remote serial node on the two serial lines.
// Assumes: Eight data bits, LSB first, BITC clocks per bit.
// Notes: Line rests low between frames so each idle rise arms the receiver.
`timescale 1ns/1ps
`default_nettype none
module remote_node
    import serial_channel_pkg::*;
#(
    parameter int BITC = 8
)(
    input wire logic clk_sys,
    input wire logic serial_out_pin,
    output logic serial_in_pin
);
    initial serial_in_pin = 1'b0;
    // Holds one level for nb bit times
    task automatic hold(input logic v, input int nb);
        serial_in_pin <= v;
        repeat (nb * BITC) @(posedge clk_sys);
    endtask : hold
    // Idle, start, data, optional parity, stop
    task automatic send(input logic [7:0] d, input logic [1:0] p, input bit bp, input bit bs);
        logic pb;
        pb = ((p == PAR_ODD) ? ~^d : (p == PAR_EVEN) ? ^d : 1'b0) ^ bp;
        @(posedge clk_sys);
        hold(1'b1, 3);
        hold(1'b0, 1);
        for (int i = 0; i < 8; i++) hold(d[i], 1);
        if (p != PAR_NONE) hold(pb, 1);
        hold(!bs, 1);
        hold(1'b0, 1); // Low again so the next idle gives a rising edge
    endtask : send
    // Samples each bit at its middle; pb is the bit after the data
    task automatic recv(output logic [7:0] d, output logic pb);
        wait (serial_out_pin === 1'b0);
        repeat (BITC / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge clk_sys);
            d[i] = serial_out_pin;
        end
        repeat (BITC) @(posedge clk_sys);
        pb = serial_out_pin;
    endtask : recv
endmodule : remote_node
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the serial channel core.
// Assumes: Base clock is clk_sys except in the external-clock frame, k = 4, so a bit is eight clocks.
// Notes: Register accesses leave one idle cycle between strobes.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import serial_channel_pkg::*;
;
    logic clk_sys, reset_n, reg_write, reg_read, ext_base_clk, serial_in_pin;
    logic serial_out_pin, tx_enable_irq, rx_done_irq, pb, ep;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, got, td, n_irq;
    logic [1:0] pm;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    serial_channel serial_channel_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
        .ext_base_clk(ext_base_clk), .serial_out_pin(serial_out_pin),
        .tx_enable_irq(tx_enable_irq), .rx_done_irq(rx_done_irq));
    remote_node remote_node_inst (.clk_sys(clk_sys), .serial_out_pin(serial_out_pin),
        .serial_in_pin(serial_in_pin));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] v;
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk_sys);
        chk(v & m, e & m);
    endtask : rd
    // Waits for one interrupt pulse under a bound
    task automatic wt(input bit rx);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((rx ? rx_done_irq : tx_enable_irq) !== 1'b1 && n < 3000);
        chk({7'h0, n < 3000}, 8'h01);
    endtask : wt
    task automatic rxf(input logic [7:0] d, input logic [1:0] p, input bit bp, input bit bs);
        fork
            remote_node_inst.send(d, p, bp, bs);
            wt(1'b1);
        join
    endtask : rxf
    initial begin
        reset_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        ext_base_clk = 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(OFS_BAUD_DIVIDE, RST_BAUD_DIVIDE, 8'hFF);
        rd(OFS_RX_DATA, RST_RX_DATA, 8'hFF);
        rd(4'hF, 8'h00, 8'hFF);
        wr(OFS_BAUD_DIVIDE, 8'h04);
        wr(OFS_CLOCK_SELECT, 8'h00);
        wr(OFS_FRAME_CONTROL, 8'h80);
        for (int p = 0; p < 4; p++) begin
            pm = p[1:0];
            wr(OFS_FRAME_CONTROL, {4'hE, pm, 2'b10});
            rxf(8'h5A ^ pm, pm, 1'b1, 1'b0);
            rd(OFS_RX_STATUS, {5'h0, pm[1], 2'b00}, 8'h07);
            rd(OFS_RX_DATA, 8'h5A ^ pm, 8'hFF);
            wr(OFS_RX_STATUS, 8'h00);
            rd(OFS_RX_STATUS, 8'h00, 8'h07);
            td = 8'hC1 + pm;
            ep = (pm == PAR_NONE) | ((pm == PAR_ODD) & ~^td) | ((pm == PAR_EVEN) & ^td);
            fork
                remote_node_inst.recv(got, pb);
                begin
                    fork
                        wr(OFS_TX_DATA, td);
                        wt(1'b0);
                    join
                    rd(OFS_RX_STATUS, 8'h80, 8'h80);
                end
            join
            chk(got, td);
            chk({7'h0, pb}, {7'h0, ep});
            repeat (16) @(posedge clk_sys);
        end
        rxf(8'h3C, PAR_EVEN, 1'b0, 1'b1);
        rxf(8'hC3, PAR_EVEN, 1'b0, 1'b0);
        rd(OFS_RX_STATUS, 8'h03, 8'h07);
        rd(OFS_RX_DATA, 8'h3C, 8'hFF);
        // Reception switched off mid-frame gives no completion
        n_irq = 8'h00;
        fork
            remote_node_inst.send(8'hA5, PAR_EVEN, 1'b0, 1'b0);
            begin
                repeat (60) @(posedge clk_sys);
                wr(OFS_FRAME_CONTROL, 8'hC2);
            end
            repeat (200) @(posedge clk_sys) n_irq += {7'h0, rx_done_irq};
        join
        chk(n_irq, 8'h00);
        // External base clock paces a whole frame
        wr(OFS_CLOCK_SELECT, 8'h0B);
        fork
            wr(OFS_TX_DATA, 8'hAA);
            wt(1'b0);
        join
        repeat (240) @(posedge clk_sys) ext_base_clk <= ~ext_base_clk;
        rd(OFS_RX_STATUS, 8'h00, 8'h80);
        wr(OFS_CLOCK_SELECT, 8'h00);
        fork
            wr(OFS_TX_DATA, 8'h55);
            wt(1'b0);
        join
        repeat (16) @(posedge clk_sys);
        wr(OFS_FRAME_CONTROL, 8'h00);
        repeat (4) @(posedge clk_sys);
        chk({7'h0, serial_out_pin}, 8'h01);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
